// [sdp_pkg.sv]
// Purpose: shared constants and types for the memory pin-level link
// Assumes: single-rate modelling, core_clk samples the link clock
// Notes: burst of eight beats, chopped burst of four
package sdp_pkg;
  localparam int unsigned SDP_BANK_W = 3;
  localparam int unsigned SDP_ADDR_W = 13;
  localparam int unsigned SDP_COL_W = 10;
  localparam int unsigned SDP_BYTE_W = 8;
  localparam int unsigned SDP_NBANK = 8;
  localparam int unsigned SDP_NMR = 4;
  localparam int unsigned SDP_AP_BIT = 10;
  localparam int unsigned SDP_BC_BIT = 12;
  localparam int unsigned SDP_ROW_W = 13;
  localparam int unsigned SDP_MEM_W = 7;
  localparam logic [3:0] SDP_BL_FULL = 4'h8;
  localparam logic [3:0] SDP_BL_CHOP = 4'h4;
  localparam logic [3:0] SDP_BEAT_ZERO = 4'h0;
  localparam logic [3:0] SDP_BEAT_ONE = 4'h1;
  localparam logic [2:0] SDP_DIV_HALF = 3'h5;
  localparam logic [2:0] SDP_DIV_ZERO = 3'h0;
  localparam logic [2:0] SDP_DIV_ONE = 3'h1;
  localparam logic [SDP_ADDR_W-1:0] SDP_ADDR_ZERO = 13'h0000;
  localparam logic [SDP_BYTE_W-1:0] SDP_BYTE_ZERO = 8'h00;
  localparam logic [2:0] SDP_BANK_ZERO = 3'h0;
  // Command code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] SDP_CMD_MRW = 4'h0;
  localparam logic [3:0] SDP_CMD_REF = 4'h1;
  localparam logic [3:0] SDP_CMD_PRE = 4'h2;
  localparam logic [3:0] SDP_CMD_ACT = 4'h3;
  localparam logic [3:0] SDP_CMD_WR = 4'h4;
  localparam logic [3:0] SDP_CMD_RD = 4'h5;
  localparam logic [3:0] SDP_CMD_NOP = 4'h7;
  localparam logic [3:0] SDP_CMD_DES = 4'hF;
  typedef enum logic [2:0] {
    SDP_OP_NONE, SDP_OP_ACT, SDP_OP_RD, SDP_OP_WR, SDP_OP_PRE, SDP_OP_MRW
  } sdp_op_t;
endpackage

// [sdp_if.sv]
// Purpose: pin bundle between controller and memory device
// Assumes: strobe pairs and data are three-signal two-way pins
// Notes: oe low means that party drives; wire levels resolved here
`timescale 1ns/1ns
`default_nettype none
interface sdp_if;
  import sdp_pkg::*;
  logic link_ck;
  logic link_ck_n;
  logic reset_n;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [SDP_BANK_W-1:0] bank_select_inputs;
  logic [SDP_ADDR_W-1:0] addr;
  logic [1:0] byte_write_masks;
  // Controller side drive of data and strobes
  logic [SDP_BYTE_W-1:0] c_low_o, c_high_o;
  logic c_low_oe_n, c_high_oe_n;
  logic [1:0] c_strobe_t_o, c_strobe_c_o;
  // Device side drive
  logic [SDP_BYTE_W-1:0] d_low_o, d_high_o;
  logic d_low_oe_n, d_high_oe_n;
  logic [1:0] d_strobe_t_o, d_strobe_c_o;
  // Resolved wire levels
  logic [SDP_BYTE_W-1:0] low_byte_lines, high_byte_lines;
  logic [1:0] strobe_t, strobe_c;
  assign low_byte_lines = !d_low_oe_n ? d_low_o : c_low_o;
  assign high_byte_lines = !d_high_oe_n ? d_high_o : c_high_o;
  assign strobe_t[0] = !d_low_oe_n ? d_strobe_t_o[0] : c_strobe_t_o[0];
  assign strobe_c[0] = !d_low_oe_n ? d_strobe_c_o[0] : c_strobe_c_o[0];
  assign strobe_t[1] = !d_high_oe_n ? d_strobe_t_o[1] : c_strobe_t_o[1];
  assign strobe_c[1] = !d_high_oe_n ? d_strobe_c_o[1] : c_strobe_c_o[1];
  modport ctrl (
    output link_ck, link_ck_n, reset_n, cs_n, ras_n, cas_n, we_n,
    output bank_select_inputs, addr, byte_write_masks,
    output c_low_o, c_high_o, c_low_oe_n, c_high_oe_n, c_strobe_t_o, c_strobe_c_o,
    input low_byte_lines, high_byte_lines, strobe_t, strobe_c
  );
  modport dev (
    input link_ck, link_ck_n, reset_n, cs_n, ras_n, cas_n, we_n,
    input bank_select_inputs, addr, byte_write_masks,
    output d_low_o, d_high_o, d_low_oe_n, d_high_oe_n, d_strobe_t_o, d_strobe_c_o,
    input low_byte_lines, high_byte_lines, strobe_t, strobe_c
  );
endinterface
`default_nettype wire

// [sdp_sync.sv]
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: destination clock core_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module sdp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      dout <= '0;
    end else if (ce) begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [sdp_dev.sv]
// Purpose: memory device end; decodes commands, holds banks, answers bursts
// Assumes: core_clk oversamples link clock; one beat per link clock rise
// Notes: small array model; column width trimmed to storage depth
`timescale 1ns/1ns
`default_nettype none
module sdp_dev
  import sdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  sdp_if.dev pins,
  output logic [SDP_NBANK-1:0] bank_open,
  output logic [SDP_ADDR_W-1:0] mode_reg0,
  output logic busy
);
  // All pins but reset_n share one synchroniser so clock, command and data stay aligned
  // Costs two core cycles of latency on every sample
  localparam int unsigned IW = 2 + 4 + SDP_BANK_W + SDP_ADDR_W + 2 + 2 * SDP_BYTE_W + 4;
  logic [IW-1:0] raw, s;
  wire arst = reset | !pins.reset_n;
  assign raw = {pins.link_ck, pins.link_ck_n, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n,
    pins.bank_select_inputs, pins.addr, pins.byte_write_masks, pins.high_byte_lines,
    pins.low_byte_lines, pins.strobe_t, pins.strobe_c};
  sdp_sync #(.W(IW)) u_sync (
    .core_clk(core_clk), .reset(arst), .ce(ce), .din(raw), .dout(s)
  );
  wire ck_s = s[IW-1];
  wire ck_n_s = s[IW-2];
  wire [3:0] cmd_s = s[IW-3 -: 4];
  wire [SDP_BANK_W-1:0] ba_s = s[IW-7 -: SDP_BANK_W];
  wire [SDP_ADDR_W-1:0] a_s = s[IW-7-SDP_BANK_W -: SDP_ADDR_W];
  wire [1:0] dm_s = s[4+2*SDP_BYTE_W +: 2];
  wire [SDP_BYTE_W-1:0] dhi_s = s[4+SDP_BYTE_W +: SDP_BYTE_W];
  wire [SDP_BYTE_W-1:0] dlo_s = s[4 +: SDP_BYTE_W];
  wire [1:0] st_s = s[3:2];
  wire [1:0] sc_s = s[1:0];
  // Edge detectors start low, matching the idle clock and strobe levels
  logic ck_d_reg;
  logic [1:0] st_d_reg;
  // rising true clock with falling complement
  wire ck_rise = ck_s & !ck_n_s & !ck_d_reg;
  // strobe edge only on true/complement crossing
  wire [1:0] st_edge = (st_s ^ st_d_reg) & (st_s ^ sc_s);
  function automatic sdp_op_t dec(input logic [3:0] c);
    // chip select high gives no operation
    unique case (c)
      SDP_CMD_ACT: dec = SDP_OP_ACT;
      SDP_CMD_RD: dec = SDP_OP_RD;
      SDP_CMD_WR: dec = SDP_OP_WR;
      SDP_CMD_PRE: dec = SDP_OP_PRE;
      SDP_CMD_MRW: dec = SDP_OP_MRW;
      default: dec = SDP_OP_NONE;
    endcase
  endfunction
  wire sdp_op_t op = ck_rise ? dec(cmd_s) : SDP_OP_NONE;
  // Column trimmed to seven bits: storage is 128 words per bank
  // Upper column bits are accepted but alias onto the same word
  // column from low seven bits
  wire [SDP_MEM_W-1:0] col = a_s[SDP_MEM_W-1:0];
  logic [SDP_ROW_W-1:0] row_reg [SDP_NBANK];
  logic [SDP_ADDR_W-1:0] mr_reg [SDP_NMR];
  logic [SDP_BYTE_W-1:0] mem_lo [SDP_NBANK][2**SDP_MEM_W];
  logic [SDP_BYTE_W-1:0] mem_hi [SDP_NBANK][2**SDP_MEM_W];
  logic [SDP_NBANK-1:0] open_reg;
  logic rd_reg, wr_reg, ap_reg;
  logic [3:0] beats_reg, beat_reg;
  logic [SDP_BANK_W-1:0] bank_reg;
  logic [SDP_MEM_W-1:0] ptr_reg;
  logic [SDP_BYTE_W-1:0] qlo_reg, qhi_reg;
  logic [1:0] strobe_reg;
  wire active = rd_reg | wr_reg;
  // Reads run one rise longer so the last beat is still driven when sampled
  wire [3:0] end_beat = rd_reg ? beats_reg : beats_reg - SDP_BEAT_ONE;
  wire last = beat_reg == end_beat;
  wire more = beat_reg != beats_reg;
  wire [SDP_MEM_W-1:0] wptr = ptr_reg + SDP_MEM_W'(beat_reg);
  always_ff @(posedge core_clk or posedge arst) begin
    if (arst) begin
      ck_d_reg <= 1'b0;
      st_d_reg <= 2'b00;
      // reset closes banks; array not cleared
      open_reg <= '0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      ap_reg <= 1'b0;
      beats_reg <= SDP_BEAT_ZERO;
      beat_reg <= SDP_BEAT_ZERO;
      bank_reg <= SDP_BANK_ZERO;
      ptr_reg <= '0;
      busy <= 1'b0;
      mode_reg0 <= SDP_ADDR_ZERO;
      bank_open <= '0;
    end else if (ce) begin
      ck_d_reg <= ck_s;
      st_d_reg <= st_s;
      // Status outputs copied to flops so no top output is combinational
      busy <= active;
      bank_open <= open_reg;
      mode_reg0 <= mr_reg[0];
      if (op == SDP_OP_ACT) begin
        open_reg[ba_s] <= 1'b1;
      end
      // Precharge during a burst still acts; the burst keeps its own bank
      if (op == SDP_OP_PRE) begin
        // bit ten high closes all banks
        if (a_s[SDP_AP_BIT]) open_reg <= '0;
        else open_reg[ba_s] <= 1'b0;
      end
      if ((op == SDP_OP_RD || op == SDP_OP_WR) && !active) begin
        rd_reg <= op == SDP_OP_RD;
        wr_reg <= op == SDP_OP_WR;
        bank_reg <= ba_s;
        ptr_reg <= col;
        ap_reg <= a_s[SDP_AP_BIT];
        beats_reg <= a_s[SDP_BC_BIT] ? SDP_BL_FULL : SDP_BL_CHOP;
        beat_reg <= SDP_BEAT_ZERO;
      end else if (active && ck_rise) begin
        beat_reg <= beat_reg + SDP_BEAT_ONE;
        if (last) begin
          rd_reg <= 1'b0;
          wr_reg <= 1'b0;
          if (ap_reg) open_reg[bank_reg] <= 1'b0;
        end
      end
    end
  end
  // Memory and mode registers: no reset so contents may survive
  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (op == SDP_OP_ACT) begin
        row_reg[ba_s] <= a_s;
      end
      if (op == SDP_OP_MRW) begin
        mr_reg[ba_s[1:0]] <= a_s;
      end
      // each strobe gates only its byte
      if (wr_reg && st_edge[0] && !dm_s[0]) mem_lo[bank_reg][wptr] <= dlo_s;
      if (wr_reg && st_edge[1] && !dm_s[1]) mem_hi[bank_reg][wptr] <= dhi_s;
    end
  end
  // device drives strobe with read data
  // strobe toggles with each data change
  always_ff @(posedge core_clk or posedge arst) begin
    if (arst) begin
      qlo_reg <= SDP_BYTE_ZERO;
      qhi_reg <= SDP_BYTE_ZERO;
      strobe_reg <= 2'b00;
    end else if (ce) begin
      // Read data launched on the rise, captured by the far end on the fall
      if (rd_reg && ck_rise && more) begin
        qlo_reg <= mem_lo[bank_reg][wptr];
        qhi_reg <= mem_hi[bank_reg][wptr];
        strobe_reg <= ~strobe_reg;
      end else if (!rd_reg) begin
        // Strobe returns low between bursts so the next one starts known
        strobe_reg <= 2'b00;
      end
    end
  end
  assign pins.d_low_o = qlo_reg;
  assign pins.d_high_o = qhi_reg;
  // Output enable held to the rise after the last beat
  assign pins.d_low_oe_n = !rd_reg;
  assign pins.d_high_oe_n = !rd_reg;
  assign pins.d_strobe_t_o = strobe_reg;
  assign pins.d_strobe_c_o = ~strobe_reg;
endmodule
`default_nettype wire

// [sdp_ctrl.sv]
// Purpose: controller end; issues one command, moves one burst
// Assumes: link clock made here by divide of core_clk
// Notes: one request at a time; req taken while ready
`timescale 1ns/1ns
`default_nettype none
module sdp_ctrl
  import sdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  sdp_if.ctrl pins,
  input wire logic req,
  input wire logic [2:0] req_op,
  input wire logic [SDP_BANK_W-1:0] req_bank,
  input wire logic [SDP_ADDR_W-1:0] req_addr,
  input wire logic [2*SDP_BYTE_W-1:0] wdata,
  input wire logic [1:0] wmask,
  output logic ready,
  output logic [2*SDP_BYTE_W-1:0] rdata,
  output logic rvalid
);
  logic [2:0] div_reg;
  logic ck_reg, rst_n_reg;
  logic [3:0] cmd_reg;
  logic [SDP_BANK_W-1:0] ba_reg;
  logic [SDP_ADDR_W-1:0] a_reg;
  logic wr_reg, rd_reg, pend_reg;
  logic [3:0] beat_reg, beats_reg;
  logic [1:0] st_reg;
  logic [2*SDP_BYTE_W-1:0] d_reg;
  logic [1:0] dm_reg;
  wire tick = div_reg == SDP_DIV_HALF;
  wire rise = tick & !ck_reg;
  wire fall = tick & ck_reg;
  wire [2:0] div_next = tick ? SDP_DIV_ZERO : div_reg + SDP_DIV_ONE;
  wire ck_next = tick ? !ck_reg : ck_reg;
  // Accept only in the low phase, so a rise follows and pins stay still while high
  wire win = !ck_next && div_next != SDP_DIV_HALF;
  wire [2*SDP_BYTE_W-1:0] rd_s;
  sdp_sync #(.W(2 * SDP_BYTE_W)) u_rsync (
    .core_clk(core_clk), .reset(reset), .ce(ce),
    .din({pins.high_byte_lines, pins.low_byte_lines}), .dout(rd_s)
  );
  wire sdp_op_t op = sdp_op_t'(req_op);
  wire [3:0] cmd_enc = op == SDP_OP_ACT ? SDP_CMD_ACT : op == SDP_OP_RD ? SDP_CMD_RD :
    op == SDP_OP_WR ? SDP_CMD_WR : op == SDP_OP_PRE ? SDP_CMD_PRE :
    op == SDP_OP_MRW ? SDP_CMD_MRW : SDP_CMD_NOP;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_reg <= SDP_DIV_ZERO;
      ck_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      cmd_reg <= SDP_CMD_DES;
      ba_reg <= SDP_BANK_ZERO;
      a_reg <= SDP_ADDR_ZERO;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      pend_reg <= 1'b0;
      beat_reg <= SDP_BEAT_ZERO;
      beats_reg <= SDP_BEAT_ZERO;
      st_reg <= 2'b00;
      d_reg <= '0;
      dm_reg <= 2'b00;
      ready <= 1'b0;
      rdata <= '0;
      rvalid <= 1'b0;
    end else if (ce) begin
      div_reg <= tick ? SDP_DIV_ZERO : div_reg + SDP_DIV_ONE;
      if (tick) ck_reg <= !ck_reg;
      // reset pin released and held high
      rst_n_reg <= 1'b1;
      rvalid <= 1'b0;
      ready <= rst_n_reg && !pend_reg && !wr_reg && !rd_reg && !(ready && req) && win;
      if (ready && req) begin
        pend_reg <= 1'b1;
        ba_reg <= req_bank;
        // op-code or address onto address pins
        a_reg <= req_addr;
        cmd_reg <= cmd_enc;
        beats_reg <= req_addr[SDP_BC_BIT] ? SDP_BL_FULL : SDP_BL_CHOP;
      end else if (fall && pend_reg) begin
        // Command leaves after the rise that sampled it
        pend_reg <= 1'b0;
        cmd_reg <= SDP_CMD_DES;
        wr_reg <= cmd_reg == SDP_CMD_WR;
        rd_reg <= cmd_reg == SDP_CMD_RD;
        beat_reg <= SDP_BEAT_ZERO;
        d_reg <= wdata;
        dm_reg <= wmask;
      end else if (rise && (wr_reg || (rd_reg && beat_reg != beats_reg))) begin
        // write strobe flips mid-eye, at rise
        if (wr_reg) st_reg <= ~st_reg;
        beat_reg <= beat_reg + SDP_BEAT_ONE;
        if (wr_reg && beat_reg == beats_reg - SDP_BEAT_ONE) wr_reg <= 1'b0;
      end else if (fall && rd_reg && beat_reg != SDP_BEAT_ZERO) begin
        // Last read beat is taken on the fall after the final rise
        rdata <= rd_s;
        rvalid <= 1'b1;
        if (beat_reg == beats_reg) rd_reg <= 1'b0;
      end else if (fall && wr_reg) begin
        d_reg <= wdata;
        dm_reg <= wmask;
      end
      if (!wr_reg) st_reg <= 2'b00;
    end
  end
  assign pins.link_ck = ck_reg;
  assign pins.link_ck_n = !ck_reg;
  assign pins.reset_n = rst_n_reg;
  assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = cmd_reg;
  assign pins.bank_select_inputs = ba_reg;
  assign pins.addr = a_reg;
  // lower and upper bytes carried apart
  assign pins.c_low_o = d_reg[SDP_BYTE_W-1:0];
  assign pins.c_high_o = d_reg[2*SDP_BYTE_W-1:SDP_BYTE_W];
  assign pins.byte_write_masks = dm_reg;
  assign pins.c_low_oe_n = !wr_reg;
  assign pins.c_high_oe_n = !wr_reg;
  assign pins.c_strobe_t_o = st_reg;
  assign pins.c_strobe_c_o = ~st_reg;
endmodule
`default_nettype wire

// [sdp_assertions.sv]
// Purpose: pin-level checks on the controller-device link
// Assumes: ce held high, link clock made by the controller
// Notes: sees the interface signals only
`timescale 1ns/1ns
`default_nettype none
module sdp_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_ck,
  input wire logic link_ck_n,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic c_low_oe_n,
  input wire logic c_high_oe_n,
  input wire logic d_low_oe_n,
  input wire logic d_high_oe_n,
  input wire logic [1:0] strobe_t,
  input wire logic [1:0] strobe_c
);
  AST_CK_PAIR: assert property (@(posedge core_clk) disable iff (reset)
    link_ck_n == !link_ck) else $error("link clock pair not complementary");
  AST_CK_HIGH_PHASE: assert property (@(posedge core_clk) disable iff (reset)
    $rose(link_ck) |-> link_ck [*6] ##1 !link_ck) else $error("link clock high phase wrong");
  AST_CMD_STABLE: assert property (@(posedge core_clk) disable iff (reset)
    link_ck && $past(link_ck) |-> $stable({cs_n, ras_n, cas_n, we_n, addr}))
    else $error("command changed while link clock high");
  AST_RESET_PIN_HIGH: assert property (@(posedge core_clk) disable iff (reset)
    !$past(reset) |-> reset_n) else $error("reset pin low in operation");
  AST_LOW_ONE_DRIVER: assert property (@(posedge core_clk) disable iff (reset)
    !(!c_low_oe_n && !d_low_oe_n)) else $error("both ends drive low byte");
  AST_HIGH_ONE_DRIVER: assert property (@(posedge core_clk) disable iff (reset)
    !(!c_high_oe_n && !d_high_oe_n)) else $error("both ends drive high byte");
  AST_LOW_STROBE_DIFF: assert property (@(posedge core_clk) disable iff (reset)
    !c_low_oe_n || !d_low_oe_n |-> strobe_c[0] == !strobe_t[0])
    else $error("low strobe pair not differential");
  AST_HIGH_STROBE_DIFF: assert property (@(posedge core_clk) disable iff (reset)
    !c_high_oe_n || !d_high_oe_n |-> strobe_c[1] == !strobe_t[1])
    else $error("high strobe pair not differential");
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: drives the controller user side and judges both ends
// Assumes: one request at a time, ready and busy gate each request
// Notes: write data held constant through each burst
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sdp_pkg::*;
  logic core_clk, reset, req, ready, rvalid, busy;
  logic [2:0] req_op, req_bank;
  logic [12:0] req_addr, mode_reg0;
  logic [15:0] wdata, rdata, rd_last;
  logic [1:0] wmask;
  logic [7:0] bank_open;
  int errors, checks_done, rv_cnt;
  sdp_if pins_if();
  sdp_ctrl sdp_ctrl_inst (.core_clk(core_clk), .reset(reset), .ce(1'b1), .pins(pins_if),
    .req(req), .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr), .wdata(wdata),
    .wmask(wmask), .ready(ready), .rdata(rdata), .rvalid(rvalid));
  sdp_dev sdp_dev_inst (.core_clk(core_clk), .reset(reset), .ce(1'b1), .pins(pins_if),
    .bank_open(bank_open), .mode_reg0(mode_reg0), .busy(busy));
  sdp_assertions sdp_assertions_inst (.core_clk(core_clk), .reset(reset),
    .link_ck(pins_if.link_ck), .link_ck_n(pins_if.link_ck_n), .reset_n(pins_if.reset_n),
    .cs_n(pins_if.cs_n), .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n),
    .addr(pins_if.addr), .c_low_oe_n(pins_if.c_low_oe_n), .c_high_oe_n(pins_if.c_high_oe_n),
    .d_low_oe_n(pins_if.d_low_oe_n), .d_high_oe_n(pins_if.d_high_oe_n),
    .strobe_t(pins_if.strobe_t), .strobe_c(pins_if.strobe_c));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (rvalid === 1'b1) begin
      rv_cnt <= rv_cnt + 1;
      rd_last <= rdata;
    end
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for both ends idle
  task automatic wait_idle;
    int n;
    n = 0;
    while (!(ready === 1'b1 && busy === 1'b0) && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      give_verdict;
    end
  endtask
  task automatic do_op(input sdp_op_t op, input logic [2:0] bk, input logic [12:0] ad,
                       input logic [15:0] wd, input logic [1:0] wm);
    wait_idle;
    // Ready seen at this falling edge holds through the next rising edge
    rv_cnt = 0;
    req = 1'b1;
    req_op = op;
    req_bank = bk;
    req_addr = ad;
    wdata = wd;
    wmask = wm;
    @(negedge core_clk);
    req = 1'b0;
    @(negedge core_clk);
    wait_idle;
  endtask
  task automatic t_mode;
    do_op(SDP_OP_MRW, 3'h0, 13'h1A5B, 16'h0000, 2'h0);
    check({3'h0, mode_reg0}, 16'h1A5B);
    do_op(SDP_OP_MRW, 3'h1, 13'h0F0F, 16'h0000, 2'h0);
    check({3'h0, mode_reg0}, 16'h1A5B);
    $display("test mode done");
  endtask
  task automatic t_act;
    do_op(SDP_OP_ACT, 3'h3, 13'h1FFF, 16'h0000, 2'h0);
    do_op(SDP_OP_ACT, 3'h5, 13'h0001, 16'h0000, 2'h0);
    check({8'h00, bank_open}, 16'h0028);
    $display("test activate done");
  endtask
  task automatic t_burst;
    // Column bit eleven set: must land on the same column
    do_op(SDP_OP_WR, 3'h3, 13'h1805, 16'hA55A, 2'h0);
    do_op(SDP_OP_RD, 3'h3, 13'h1005, 16'h0000, 2'h0);
    check(16'(rv_cnt), 16'h0008);
    check(rd_last, 16'hA55A);
    do_op(SDP_OP_RD, 3'h3, 13'h0005, 16'h0000, 2'h0);
    check(16'(rv_cnt), 16'h0004);
    check(rd_last, 16'hA55A);
    $display("test burst done");
  endtask
  task automatic t_mask;
    do_op(SDP_OP_WR, 3'h3, 13'h1005, 16'h3C77, 2'h2);
    do_op(SDP_OP_RD, 3'h3, 13'h1005, 16'h0000, 2'h0);
    check(rd_last, 16'hA577);
    do_op(SDP_OP_WR, 3'h3, 13'h1005, 16'h3C77, 2'h1);
    do_op(SDP_OP_RD, 3'h3, 13'h1005, 16'h0000, 2'h0);
    check(rd_last, 16'h3C77);
    $display("test mask done");
  endtask
  task automatic t_autopre;
    do_op(SDP_OP_RD, 3'h3, 13'h1405, 16'h0000, 2'h0);
    check(rd_last, 16'h3C77);
    check({8'h00, bank_open}, 16'h0020);
    $display("test auto precharge done");
  endtask
  task automatic t_pre;
    do_op(SDP_OP_PRE, 3'h5, 13'h0000, 16'h0000, 2'h0);
    check({8'h00, bank_open}, 16'h0000);
    do_op(SDP_OP_ACT, 3'h1, 13'h0010, 16'h0000, 2'h0);
    do_op(SDP_OP_ACT, 3'h2, 13'h0020, 16'h0000, 2'h0);
    do_op(SDP_OP_PRE, 3'h1, 13'h0000, 16'h0000, 2'h0);
    check({8'h00, bank_open}, 16'h0004);
    do_op(SDP_OP_ACT, 3'h7, 13'h0030, 16'h0000, 2'h0);
    do_op(SDP_OP_PRE, 3'h0, 13'h0400, 16'h0000, 2'h0);
    check({8'h00, bank_open}, 16'h0000);
    $display("test precharge done");
  endtask
  task automatic t_reset;
    do_op(SDP_OP_ACT, 3'h6, 13'h0002, 16'h0000, 2'h0);
    check({8'h00, bank_open}, 16'h0040);
    @(negedge core_clk);
    reset = 1'b1;
    @(negedge core_clk);
    check({8'h00, bank_open}, 16'h0000);
    reset = 1'b0;
    wait_idle;
    do_op(SDP_OP_ACT, 3'h4, 13'h0003, 16'h0000, 2'h0);
    check({8'h00, bank_open}, 16'h0010);
    $display("test reset done");
  endtask
  initial begin
    errors = 0;
    checks_done = 0;
    rv_cnt = 0;
    rd_last = 16'h0000;
    reset = 1'b1;
    req = 1'b0;
    req_op = 3'h0;
    req_bank = 3'h0;
    req_addr = 13'h0000;
    wdata = 16'h0000;
    wmask = 2'h0;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    t_mode;
    t_act;
    t_burst;
    t_mask;
    t_autopre;
    t_pre;
    t_reset;
    give_verdict;
  end
endmodule
`default_nettype wire
